// File: src/lcdnp_defs.vh
// Purpose: constants for the LCD nibble instruction port
// Assumes: 200 MHz clock, 5 ns period
// Notes: times are in their own unit; cycle counts derive from them
`ifndef LCDNP_DEFS_VH
`define LCDNP_DEFS_VH

// ============================================================
// Clock and timing
`define LCDNP_CLK_MHZ 200
`define LCDNP_PWRUP_MS 1000
`define LCDNP_PWRUP_CYC (`LCDNP_PWRUP_MS * 1000 * `LCDNP_CLK_MHZ)
`define LCDNP_WAKE1_MS 5
`define LCDNP_WAKE1_CYC (`LCDNP_WAKE1_MS * 1000 * `LCDNP_CLK_MHZ)
// Strobe phase times in ns: setup, high, hold after fall
`define LCDNP_SETUP_NS 100
`define LCDNP_SETUP_CYC ((`LCDNP_SETUP_NS * `LCDNP_CLK_MHZ + 999) / 1000)
`define LCDNP_HIGH_NS 500
`define LCDNP_HIGH_CYC ((`LCDNP_HIGH_NS * `LCDNP_CLK_MHZ + 999) / 1000)
`define LCDNP_HOLD_NS 500
`define LCDNP_HOLD_CYC ((`LCDNP_HOLD_NS * `LCDNP_CLK_MHZ + 999) / 1000)
// Gap after each instruction, the minimal delay the display needs, in us
`define LCDNP_GAP_US 50
`define LCDNP_GAP_CYC (`LCDNP_GAP_US * `LCDNP_CLK_MHZ)

// ============================================================
// Pin map
`define LCDNP_RW_LO 2
`define LCDNP_RS_LO 3
`define LCDNP_DB_LO 4
`define LCDNP_RW_HI 10
`define LCDNP_RS_HI 11
`define LCDNP_DB_HI 12

// ============================================================
// Fixed instructions
`define LCDNP_WAKE 8'h30
`define LCDNP_BUS4 8'h20
`define LCDNP_FUNC_RST 8'h28
`define LCDNP_DISP_RST 8'h0C
`define LCDNP_ENTRY_RST 8'h06
`endif

// File: src/lcdnp_nibble.v
// Purpose: one strobed nibble transfer with setup, high and hold phases
// Assumes: same clock as caller; start only when idle
// Notes: done pulses for one cycle as the hold phase ends
`timescale 1ns/1ps
`default_nettype none
`include "lcdnp_defs.vh"

module lcdnp_nibble (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire start,
	output reg strobe,
	output reg done,
	output wire idle
);
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_SETUP = 4'h2;
	localparam [3:0] S_HIGH = 4'h4;
	localparam [3:0] S_HOLD = 4'h8;
	localparam integer C_SETUP_I = `LCDNP_SETUP_CYC;
	localparam integer C_HIGH_I = `LCDNP_HIGH_CYC;
	localparam integer C_HOLD_I = `LCDNP_HOLD_CYC;
	// Phase counts fit eight bits at this clock; cut on purpose
	localparam [7:0] C_SETUP = C_SETUP_I[7:0];
	localparam [7:0] C_HIGH = C_HIGH_I[7:0];
	localparam [7:0] C_HOLD = C_HOLD_I[7:0];

	reg [3:0] state;
	reg [7:0] cnt;

	assign idle = state[0];

	// ============================================================
	// Phase sequencer
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			cnt <= 8'h00;
			strobe <= 1'b0;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			case (state)
				S_IDLE: begin
					if (start) begin
						state <= S_SETUP;
						cnt <= C_SETUP - 8'h01;
					end
				end
				S_SETUP: begin
					if (cnt == 8'h00) begin
						state <= S_HIGH;
						strobe <= 1'b1;
						cnt <= C_HIGH - 8'h01;
					end else cnt <= cnt - 8'h01;
				end
				S_HIGH: begin
					if (cnt == 8'h00) begin
						state <= S_HOLD;
						strobe <= 1'b0; // Data latches on this falling edge
						cnt <= C_HOLD - 8'h01;
					end else cnt <= cnt - 8'h01;
				end
				S_HOLD: begin
					if (cnt == 8'h00) begin
						state <= S_IDLE;
						done <= 1'b1;
					end else cnt <= cnt - 8'h01;
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule // lcdnp_nibble
`default_nettype wire

// File: src/lcdnp_port.v
// Purpose: send 8-bit instructions to a character LCD over a 4-bit bus
// Assumes: one clock, display wired to the selected seven-pin group
// Notes: runs the power-up init sequence itself before accepting requests
`timescale 1ns/1ps
`default_nettype none
`include "lcdnp_defs.vh"

module lcdnp_port #(
	parameter PWRUP_CYC = `LCDNP_PWRUP_CYC,
	parameter WAKE1_CYC = `LCDNP_WAKE1_CYC,
	parameter GAP_CYC = `LCDNP_GAP_CYC
) (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire skip_pwrup_wait,
	input wire [7:0] cfg_func,
	input wire [7:0] cfg_disp,
	input wire [7:0] cfg_entry,
	input wire req,
	input wire [3:0] pin_sel,
	input wire [7:0] lcd_instruction_send,
	output reg busy,
	output reg refused,
	output reg init_done,
	output reg [15:0] pin_out,
	output reg [15:0] pin_oe
);
	// ============================================================
	// States
	localparam [5:0] S_PWRUP = 6'h01;
	localparam [5:0] S_INIT = 6'h02;
	localparam [5:0] S_IDLE = 6'h04;
	localparam [5:0] S_NIB = 6'h08;
	localparam [5:0] S_WAIT = 6'h10;
	localparam [5:0] S_GAP = 6'h20;
	localparam [31:0] C_PWRUP = PWRUP_CYC;
	localparam [31:0] C_WAKE1 = WAKE1_CYC;
	localparam [31:0] C_GAP = GAP_CYC;

	reg [5:0] state;
	reg [31:0] cnt;
	reg [2:0] step;
	reg [7:0] instr;
	reg [3:0] sel;
	reg lower;
	reg nib_start;
	wire nib_strobe;
	wire nib_done;
	reg [7:0] init_instr;
	reg sel_ok;
	reg [3:0] nibble;
	wire [31:0] gap_lim;
	wire gap_last;
	wire drive_pins;

	lcdnp_nibble u_nib (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.start(nib_start),
		.strobe(nib_strobe),
		.done(nib_done),
		.idle()
	);

	// ============================================================
	// Init instruction table; steps 0..3 are fixed, 4..6 configurable
	always @* begin
		case (step)
			3'h0, 3'h1, 3'h2: init_instr = `LCDNP_WAKE;
			3'h3: init_instr = `LCDNP_BUS4;
			3'h4: init_instr = cfg_func;
			3'h5: init_instr = cfg_disp;
			default: init_instr = cfg_entry;
		endcase
		sel_ok = (pin_sel == 4'h0) || (pin_sel == 4'h1) || (pin_sel == 4'h8) || (pin_sel == 4'h9);
		nibble = lower ? instr[3:0] : instr[7:4];
	end

	// ============================================================
	// Gap length and pin release
	// The first wake-up needs the long pause; every other step only the short one
	// A zero-length gap would wrap the limit, so both counts must stay above zero
	assign gap_lim = (!init_done && step == 3'h0) ? C_WAKE1 : C_GAP;
	assign gap_last = (cnt >= gap_lim - 32'h00000001);
	// Release the pins in the same cycle busy falls, so an idle port never drives
	assign drive_pins = (state == S_NIB) || (state == S_WAIT) || (state == S_GAP && !gap_last);

	// ============================================================
	// Sequencer: power-up wait, init steps, then single instructions
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_PWRUP;
			cnt <= 32'h00000000;
			step <= 3'h0;
			instr <= 8'h00;
			sel <= 4'h0;
			lower <= 1'b0;
			nib_start <= 1'b0;
			busy <= 1'b1;
			refused <= 1'b0;
			init_done <= 1'b0;
		end else if (ce) begin
			nib_start <= 1'b0;
			refused <= 1'b0;
			case (state)
				S_PWRUP: begin
					// Long wait lets the display self-initialise first
					if (skip_pwrup_wait || cnt >= C_PWRUP - 32'h00000001) begin
						state <= S_INIT;
						cnt <= 32'h00000000;
					end else cnt <= cnt + 32'h00000001;
				end
				S_INIT: begin
					// Init uses the selector as it stands when each step starts
					instr <= init_instr;
					sel <= sel_ok ? pin_sel : 4'h0;
					lower <= 1'b0;
					nib_start <= 1'b1;
					state <= S_NIB;
				end
				S_IDLE: begin
					if (req) begin
						if (sel_ok) begin
							instr <= lcd_instruction_send;
							sel <= pin_sel;
							lower <= 1'b0;
							nib_start <= 1'b1;
							busy <= 1'b1;
							state <= S_NIB;
						end else refused <= 1'b1;
					end
				end
				S_NIB: state <= S_WAIT;
				S_WAIT: begin
					if (nib_done) begin
						// Wake-up steps are single 8-bit-mode nibbles; the bus switch and all after go as two
						if (!lower && (init_done || step > 3'h2)) begin
							lower <= 1'b1;
							nib_start <= 1'b1;
							state <= S_NIB;
						end else begin
							state <= S_GAP;
							cnt <= 32'h00000000;
						end
					end
				end
				S_GAP: begin
					if (gap_last) begin
						cnt <= 32'h00000000;
						if (init_done) begin
							state <= S_IDLE;
							busy <= 1'b0;
						end else if (step == 3'h6) begin
							init_done <= 1'b1;
							state <= S_IDLE;
							busy <= 1'b0;
						end else begin
							step <= step + 3'h1;
							state <= S_INIT;
						end
					end else cnt <= cnt + 32'h00000001;
				end
				default: state <= S_PWRUP;
			endcase
		end
	end

	// ============================================================
	// Pin drive: seven pins of the chosen group; select and read/write low
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
		end else if (ce) begin
			pin_out <= 16'h0000;
			pin_oe <= 16'h0000;
			// Pins lag the state by one register, so release is decided a cycle early
			if (drive_pins) begin
				pin_oe[sel] <= 1'b1;
				pin_out[sel] <= nib_strobe;
				if (sel[3]) begin
					pin_oe[`LCDNP_RW_HI] <= 1'b1;
					pin_oe[`LCDNP_RS_HI] <= 1'b1;
					pin_oe[15:12] <= 4'hF;
					pin_out[15:12] <= nibble;
				end else begin
					pin_oe[`LCDNP_RW_LO] <= 1'b1;
					pin_oe[`LCDNP_RS_LO] <= 1'b1;
					pin_oe[7:4] <= 4'hF;
					pin_out[7:4] <= nibble;
				end
			end
		end
	end
endmodule // lcdnp_port
`default_nettype wire

// File: test/lcdnp_port_properties.sv
// Purpose: port-level assertions for lcdnp_port
// Assumes: single clock, nrst async active low
// Notes: pwr_cnt lets the power-up wait be checked without a long repetition
`timescale 1ns/1ps
`default_nettype none
module lcdnp_port_properties #(
	parameter PWRUP_CYC = 100
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic skip_pwrup_wait,
	input wire logic req,
	input wire logic [3:0] pin_sel,
	input wire logic busy,
	input wire logic refused,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe
);
	int pwr_cnt;
	wire logic sel_ok = pin_sel inside {4'h0, 4'h1, 4'h8, 4'h9};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ============================================================
	// Cycles since reset, saturating at the wait length
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			pwr_cnt <= 0;
		else if (ce && pwr_cnt < PWRUP_CYC)
			pwr_cnt <= pwr_cnt + 1;
	end
	property p_take; ce && req && !busy && sel_ok |=> busy; endproperty
	a_take: assert property (p_take) else $error("request not taken");
	property p_refuse; ce && req && !busy && !sel_ok |=> refused; endproperty
	a_refuse: assert property (p_refuse) else $error("bad selector not refused");
	property p_cause; refused |-> $past(req && !busy && !sel_ok); endproperty
	a_cause: assert property (p_cause) else $error("refusal without cause");
	property p_idle; !busy |-> pin_oe == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("pins driven while idle");
	property p_group; pin_oe != 16'h0000 |-> pin_oe inside {16'h00FD, 16'h00FE, 16'hFD00, 16'hFE00}; endproperty
	a_group: assert property (p_group) else $error("wrong pin group");
	property p_rwrs; pin_oe != 16'h0000 |-> (pin_out & 16'h0C0C) == 16'h0000; endproperty
	a_rwrs: assert property (p_rwrs) else $error("select or read/write high");
	property p_pwr; !skip_pwrup_wait && pwr_cnt < PWRUP_CYC |-> busy && pin_oe == 16'h0000; endproperty
	a_pwr: assert property (p_pwr) else $error("display touched too early");
	property p_frz; !ce |=> $stable(pin_out) && $stable(busy); endproperty
	a_frz: assert property (p_frz) else $error("state moved while frozen");
endmodule // lcdnp_port_properties
bind lcdnp_port lcdnp_port_properties #(.PWRUP_CYC(PWRUP_CYC)) chk_u (.clk(clk), .nrst(nrst), .ce(ce),
	.skip_pwrup_wait(skip_pwrup_wait), .req(req), .pin_sel(pin_sel), .busy(busy), .refused(refused),
	.pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// File: test/lcdnp_lcd_model.sv
// Purpose: write-only character display seen from its seven pins
// Assumes: strobe pin given by the host selector
// Notes: a nibble with select, read/write or a missing enable logs as X
`timescale 1ns/1ps
`default_nettype none
module lcdnp_lcd_model (
	input wire logic clk,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe,
	input wire logic [3:0] e_idx
);
	logic [3:0] log [$];
	logic e_q = 1'b0;
	logic four = 1'b0;
	logic [4:0] b;
	logic [3:0] n;
	// ============================================================
	// Latch on the strobe fall, as the display does; hold keeps data valid
	always @(posedge clk) begin
		b = {1'b0, e_idx[3], 3'h0};
		n = pin_out[b + 5'd4 +: 4];
		if (e_q && !pin_out[e_idx]) begin
			if (pin_out[b + 5'd2] || pin_out[b + 5'd3] || pin_oe[b + 5'd7 -: 6] !== 6'h3F)
				n = 4'hX;
			log.push_back(n);
			if (!four && n == 4'h2)
				four <= 1'b1;
		end
		e_q <= pin_out[e_idx];
	end
endmodule // lcdnp_lcd_model
`default_nettype wire

// File: test/lcdnp_port_tb.sv
// Purpose: directed test of lcdnp_port against a display model
// Assumes: shortened wait parameters
// Notes: the model's nibble log is compared in order
`timescale 1ns/1ps
`default_nettype none
module lcdnp_port_tb;
	logic clk = 0, nrst = 0, ce = 1, skip = 0, req = 0;
	logic [7:0] cfg_func = 8'h28, cfg_disp = 8'h0C, cfg_entry = 8'h06, cmd = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [3:0] sels [6] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'h9, 4'h0};
	logic [7:0] vals [6] = '{8'h18, 8'h10, 8'h01, 8'hC2, 8'hFF, 8'h00};
	wire [15:0] pin_out, pin_oe;
	wire busy, refused, init_done;
	int n_fail = 0, check_count = 0, waited, w1;
	initial forever #2.5 clk = ~clk;
	lcdnp_port #(.PWRUP_CYC(100), .WAKE1_CYC(50), .GAP_CYC(20)) dut_u (.clk(clk), .nrst(nrst), .ce(ce),
		.skip_pwrup_wait(skip), .cfg_func(cfg_func), .cfg_disp(cfg_disp), .cfg_entry(cfg_entry), .req(req),
		.pin_sel(sel), .lcd_instruction_send(cmd), .busy(busy), .refused(refused), .init_done(init_done),
		.pin_out(pin_out), .pin_oe(pin_oe));
	lcdnp_lcd_model model_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .e_idx(sel));
	// ============================================================
	// Compare helpers
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task nib(input logic [3:0] exp);
		logic [3:0] g;
		g = 4'hX;
		if (model_u.log.size() > 0)
			g = model_u.log.pop_front();
		chk({4'h0, g}, {4'h0, exp});
	endtask
	task byte2(input logic [7:0] c);
		nib(c[7:4]);
		nib(c[3:0]);
	endtask
	// Bounded wait for idle, sampled 1 ns after each edge; running out is a mismatch
	task idle;
		waited = 0;
		while (busy !== 1'b0 && waited < 9000) begin
			@(posedge clk);
			#1;
			waited++;
		end
		if (busy !== 1'b0) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, busy, 1'b0);
		end
	endtask
	task do_reset(input logic s);
		nrst = 0;
		skip = s;
		repeat (12) @(posedge clk);
		#1 nrst = 1;
		idle();
	endtask
	// One request; optional clock-enable stall mid-transfer
	task send(input logic [3:0] s, input logic [7:0] c, input int stall);
		idle();
		sel = s;
		cmd = c;
		req = 1;
		@(posedge clk);
		#1 req = 0;
		if (stall > 0) begin
			repeat (30) @(posedge clk);
			#1 ce = 0;
			repeat (stall) @(posedge clk);
			#1 ce = 1;
		end
		repeat (2) @(posedge clk);
		#1;
		idle();
	endtask
	task init_chk(input logic [7:0] f, input logic [7:0] d, input logic [7:0] e);
		repeat (3) nib(4'h3);
		byte2(8'h20);
		byte2(f);
		byte2(d);
		byte2(e);
		chk({7'h0, init_done}, 8'h01);
		chk({7'h0, model_u.four}, 8'h01);
	endtask
	task tally_and_finish;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ============================================================
	// Main sequence
	initial begin
		do_reset(1'b0);
		w1 = waited;
		init_chk(8'h28, 8'h0C, 8'h06);
		foreach (sels[i]) begin
			send(sels[i], vals[i], i == 2 ? 10 : 0);
			byte2(vals[i]);
		end
		sel = 4'hA;
		req = 1;
		@(posedge clk);
		#1 req = 0;
		chk({7'h0, refused}, 8'h01);
		send(4'h1, 8'h80, 0);
		byte2(8'h80);
		{cfg_func, cfg_disp, cfg_entry, sel} = {8'h20, 8'h0F, 8'h07, 4'h8};
		do_reset(1'b1);
		chk({7'h0, (w1 - waited) inside {[95:105]}}, 8'h01);
		init_chk(8'h20, 8'h0F, 8'h07);
		tally_and_finish();
	end
	// Hang guard, about four and a half times the expected run
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule // lcdnp_port_tb
`default_nettype wire
